/* verification/spi_host_model.sv */
// host controller model driving select, serial clock and data
`timescale 1ns/1ps
module spi_host_model #(parameter H = 5) (
  input wire CLK,
  input wire miso,
  output reg sclk = 1'b0, output reg cs_n = 1'b1, output reg mosi = 1'b0,
  output reg [15:0] q = 16'h0
);
  // an edge every H clocks keeps the period above 25 ns and the prescale bound for prescale values up to 9
  task frame(input [15:0] d, input pol, input pha, input integer n);
    integer i, s;
    begin
      s = 0;
      q = 16'h0;
      sclk = pol;
      repeat (H) @(negedge CLK);
      cs_n = 1'b0;
      mosi = d[15];
      repeat (4 * H) @(negedge CLK); // two serial periods before the first edge
      for (i = 0; i < 2 * n; i = i + 1) begin
        sclk = ~sclk;
        // sample the port on its sample edge, move our data on the launch edge
        if (sclk == (pol ^ pha)) begin
          q = {q[14:0], miso};
          s = s + 1;
        end else if (s < 16) begin
          mosi = d[15 - s];
        end
        repeat (H) @(negedge CLK);
      end
      cs_n = 1'b1; // each word closed by its own select pulse
      mosi = ~mosi; // released line shows no stale bit
      repeat (2 * H) @(negedge CLK);
    end
  endtask
endmodule // spi_host_model

/* verification/spi_peripheral_port_assertions.sv */
// concurrent checks on the spi peripheral port outputs
`timescale 1ns/1ps
module spi_peripheral_port_assertions #(parameter WIDTH = 16) (
  input wire CLK, input wire SYS_RST, input wire [31:0] SERIAL_GLOBAL_CONTROL_REG,
  input wire CHIP_SELECT_N, input wire [WIDTH-1:0] TX_WORD, input wire PERIPHERAL_OUTPUT_LINE,
  input wire PERIPHERAL_OUTPUT_OE, input wire RX_VALID, input wire TX_TAKEN, input wire CLOCK_TOO_FAST
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // frame opening while the port is enabled
  sequence cs_fall; $fell(CHIP_SELECT_N) && !SERIAL_GLOBAL_CONTROL_REG[0]; endsequence
  take_on_fall_a: assert property (cs_fall |-> ##[1:5] TX_TAKEN) else $error("no capture");
  take_pulse_a: assert property (TX_TAKEN |=> !TX_TAKEN) else $error("long capture");
  valid_pulse_a: assert property (RX_VALID |=> !RX_VALID) else $error("long valid");
  msb_first_a: assert property (TX_TAKEN |-> PERIPHERAL_OUTPUT_OE &&
    PERIPHERAL_OUTPUT_LINE == TX_WORD[WIDTH-1]) else $error("msb");
  role_off_a: assert property (SERIAL_GLOBAL_CONTROL_REG[0] [*2] |-> !PERIPHERAL_OUTPUT_OE) else $error("on");
  idle_quiet_a: assert property (CHIP_SELECT_N [*5] |-> !PERIPHERAL_OUTPUT_OE) else $error("idle drive");
  out_low_a: assert property (!PERIPHERAL_OUTPUT_OE |-> !PERIPHERAL_OUTPUT_LINE) else $error("line");
  fast_held_a: assert property (CLOCK_TOO_FAST |=> CLOCK_TOO_FAST) else $error("flag lost");
endmodule // spi_peripheral_port_assertions

/* verification/spi_peripheral_port_test.sv */
// randomised bench for the spi peripheral port
`timescale 1ns/1ps
module spi_peripheral_port_test;
  reg CLK = 1'b0, SYS_RST = 1'b1;
  reg [31:0] gcr = 32'h0, fmt = 32'h0;
  reg [15:0] tx = 16'h0;
  wire sclk, cs_n, mosi, miso, oe, rxv, tk, fast;
  wire [15:0] rx;
  integer n_mismatch = 0, total_checks = 0, nv = 0, v, i;
  always #2 CLK = ~CLK;
  spi_peripheral_port DUT (.CLK(CLK), .SYS_RST(SYS_RST), .SERIAL_GLOBAL_CONTROL_REG(gcr), .SERIAL_FORMAT_REG(fmt),
    .SERIAL_CLOCK_PIN(sclk), .CHIP_SELECT_N(cs_n), .PERIPHERAL_INPUT_LINE(mosi), .TX_WORD(tx), .RX_WORD(rx),
    .PERIPHERAL_OUTPUT_LINE(miso), .PERIPHERAL_OUTPUT_OE(oe), .RX_VALID(rxv), .TX_TAKEN(tk), .CLOCK_TOO_FAST(fast));
  spi_host_model host (.CLK(CLK), .miso(miso), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .q());
  // counted on the clock, so a pulse inside a frame is never missed
  always @(posedge CLK) if (rxv === 1'b1) nv <= nv + 1;
  task chk(input string s, input [15:0] e, input [15:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) n_mismatch = n_mismatch + 1;
      if (g !== e) $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task run(input [15:0] w, input [1:0] m, input [7:0] ps, input integer n, input integer e);
    begin
      tx = ~w;
      fmt = {14'h0, m, ps, 8'h00}; // polarity 17, phase 16, prescale 15:8
      v = nv;
      host.frame(w, m[1], m[0], n);
      chk("words", 16'(v + e), 16'(nv));
      if (e > 0) chk("rx", w, rx);
      if (e > 0) chk("tx", tx, host.q);
      $display("test %h done", w);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    v = $urandom(32'h5C06);
    repeat (12) @(negedge CLK);
    SYS_RST = 1'b0;
    run(16'hFFFF, 2'b00, 8'h00, 8, 0);
    gcr = 32'h1;
    run(16'h0F0F, 2'b10, 8'h00, 16, 0);
    gcr = 32'h0;
    // random words through all four modes, first one right after a frame sent with the port disabled
    for (i = 0; i < 8; i = i + 1) run((i == 0) ? 16'h8001 : 16'($urandom), i[1:0], 8'($urandom % 8), 16, 1);
    chk("fast", 16'h0, {15'h0, fast});
    run(16'hA5A5, 2'b11, 8'h14, 16, 1);
    chk("fast", 16'h1, {15'h0, fast});
    SYS_RST = 1'b1;
    repeat (12) @(negedge CLK);
    SYS_RST = 1'b0;
    chk("fast", 16'h0, {15'h0, fast});
    test_done;
  end
endmodule // spi_peripheral_port_test
bind spi_peripheral_port spi_peripheral_port_assertions #(.WIDTH(WIDTH)) chk_i (.CLK(CLK), .SYS_RST(SYS_RST),
  .SERIAL_GLOBAL_CONTROL_REG(SERIAL_GLOBAL_CONTROL_REG), .CHIP_SELECT_N(CHIP_SELECT_N), .TX_WORD(TX_WORD),
  .PERIPHERAL_OUTPUT_LINE(PERIPHERAL_OUTPUT_LINE), .PERIPHERAL_OUTPUT_OE(PERIPHERAL_OUTPUT_OE),
  .RX_VALID(RX_VALID), .TX_TAKEN(TX_TAKEN), .CLOCK_TOO_FAST(CLOCK_TOO_FAST));

/* verilog/spi_peripheral_port.v */
// spi peripheral-role port running on the subsystem bus clock
`timescale 1ns/1ps
`include "spi_peripheral_port_consts.vh"
//
// Contract
// [RQ1] The port acts as a peripheral with the serial clock as input while role select bit 0 of the global control is clear.
// [RQ2] Clock phase comes from format bit 16, clear for phase 0 and set for phase 1.
// [RQ3] Clock polarity at format bit 17 picks which serial clock edge is active.
// [RQ4] Prescale bits 15:8 bound the serial clock period to (value+1) bus clocks, or two for zero, and never under 25 ns.
// [RQ5] Polarity/phase 0/0 or 1/1 launch after the rising edge and sample on the falling edge; other pairs use opposite edges.
// [RQ6] The host waits two serial clock periods after select falls before the first clock edge.
// [RQ7] The host frames every 16 bits with its own select pulse.
// [RQ8] Each select low period is one 16-bit word and the bit counter clears when select rises.
//
// timing notes
//   every pin passes two flip-flops and an edge is seen one cycle later,
//   so a serial clock edge acts two to three bus clocks after the pin moves.
//   a serial half period under about three bus clocks can be missed;
//   the too-fast flag is the only hint of that, so keep the prescale honest.
//   the data pin is synchronised alongside the clock, so the host must keep
//   it steady across a sample edge rather than move it on that edge.
//   output data changes two to three bus clocks after the launch edge,
//   well inside the half period that the prescale bound leaves.
//   when the first serial edge of a frame is a launch edge, the msb already
//   sits on the line from select fall, so that edge is skipped, not shifted.
//   a frame cut short delivers no word; the counter restarts at select rise.
//   the output is driven only while a frame is open; outside a frame the
//   line is held low so no stale bit leaks out of the last word.
//
module spi_peripheral_port #(
  parameter WIDTH = `WORD_BITS
) (
  input  wire             CLK,
  input  wire             SYS_RST,
  input  wire [31:0]      SERIAL_GLOBAL_CONTROL_REG,
  input  wire [31:0]      SERIAL_FORMAT_REG,
  input  wire             SERIAL_CLOCK_PIN,
  input  wire             CHIP_SELECT_N,
  input  wire             PERIPHERAL_INPUT_LINE,
  input  wire [WIDTH-1:0] TX_WORD,
  output reg              PERIPHERAL_OUTPUT_LINE,
  output reg              PERIPHERAL_OUTPUT_OE,
  output reg  [WIDTH-1:0] RX_WORD,
  output reg              RX_VALID,
  output reg              TX_TAKEN,
  output reg              CLOCK_TOO_FAST
);

  // two-flop synchronisers for all pins
  reg [1:0] sclk_sync_reg;
  reg [1:0] cs_sync_reg;
  reg [1:0] din_sync_reg;
  reg       sclk_prev_reg;
  reg       cs_prev_reg;

  // serial clock pin and its edge history
  always @(posedge CLK) begin
    if (SYS_RST) begin
      sclk_sync_reg <= 2'h0;
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[0], SERIAL_CLOCK_PIN};
      sclk_prev_reg <= sclk_sync_reg[1];
    end
  end

  // select pin; resets to idle high so no false frame follows reset
  always @(posedge CLK) begin
    if (SYS_RST) begin
      cs_sync_reg <= 2'h3;
      cs_prev_reg <= 1'b1;
    end else begin
      cs_sync_reg <= {cs_sync_reg[0], CHIP_SELECT_N};
      cs_prev_reg <= cs_sync_reg[1];
    end
  end

  // data pin, same depth as the clock so both arrive together
  always @(posedge CLK) begin
    if (SYS_RST) begin
      din_sync_reg <= 2'h0;
    end else begin
      din_sync_reg <= {din_sync_reg[0], PERIPHERAL_INPUT_LINE};
    end
  end

  wire       sclk_s   = sclk_sync_reg[1];
  wire       cs_n_s   = cs_sync_reg[1];
  wire       enabled  = ~SERIAL_GLOBAL_CONTROL_REG[`ROLE_SELECT_BIT]; // [RQ1]
  wire       phase    = SERIAL_FORMAT_REG[`PHASE_BIT];                 // [RQ2]
  wire       polarity = SERIAL_FORMAT_REG[`POLARITY_BIT];              // [RQ3]
  wire [7:0] prescale_value = SERIAL_FORMAT_REG[`PRESCALE_MSB:`PRESCALE_LSB];
  wire       rise     = sclk_s & ~sclk_prev_reg;
  wire       fall     = ~sclk_s & sclk_prev_reg;
  wire       cs_rise  = cs_n_s & ~cs_prev_reg;
  wire       cs_fall  = ~cs_n_s & cs_prev_reg;
  // launch on rising when polarity equals phase, sample on the other edge
  wire       launch_edge = (polarity == phase) ? rise : fall;           // [RQ5]
  wire       sample_edge = (polarity == phase) ? fall : rise;           // [RQ5]
  wire       in_frame    = enabled & ~cs_n_s;

  // 25 ns floor expressed in bus clocks, rounded up
  localparam [8:0] MIN_CYCLES = `MIN_SCLK_CYCLES;

  // least legal serial period in bus clocks
  function [8:0] min_period;
    input [7:0] ps;
    begin
      if (ps == 8'h00)
        min_period = 9'h002;
      else
        min_period = {1'b0, ps} + 9'h001;
      if (min_period < MIN_CYCLES)
        min_period = MIN_CYCLES;
    end
  endfunction

  reg [4:0]       bit_count_reg;
  reg [WIDTH-1:0] shift_in_reg;
  reg [WIDTH-1:0] shift_out_reg;
  reg [8:0]       period_count_reg;
  reg             seen_sample_reg;
  reg             first_launch_reg;

  // shift engine; a word is only delivered on its 16th sample edge
  always @(posedge CLK) begin
    if (SYS_RST) begin
      bit_count_reg          <= `BIT_COUNT_RESET;
      shift_in_reg           <= {WIDTH{1'b0}};
      shift_out_reg          <= {WIDTH{1'b0}};
      PERIPHERAL_OUTPUT_LINE <= 1'b0;
      PERIPHERAL_OUTPUT_OE   <= 1'b0;
      RX_WORD                <= {WIDTH{1'b0}};
      RX_VALID               <= 1'b0;
      TX_TAKEN               <= 1'b0;
      first_launch_reg       <= 1'b0;
    end else begin
      RX_VALID             <= 1'b0;
      TX_TAKEN             <= 1'b0;
      PERIPHERAL_OUTPUT_OE <= in_frame;
      if (cs_rise || !enabled) begin
        bit_count_reg          <= `BIT_COUNT_RESET;                     // [RQ8]
        first_launch_reg       <= 1'b0;
        PERIPHERAL_OUTPUT_LINE <= 1'b0;
      end else if (cs_fall) begin
        // phase 0 frames open with a launch edge, which must not shift the msb away
        shift_out_reg          <= TX_WORD;
        PERIPHERAL_OUTPUT_LINE <= TX_WORD[WIDTH-1];
        TX_TAKEN               <= 1'b1;
        bit_count_reg          <= `BIT_COUNT_RESET;                     // [RQ8]
        first_launch_reg       <= ~phase;                               // [RQ2]
      end else if (in_frame) begin
        if (launch_edge) begin
          if (first_launch_reg) begin
            first_launch_reg <= 1'b0;
          end else begin
            shift_out_reg          <= {shift_out_reg[WIDTH-2:0], 1'b0};
            PERIPHERAL_OUTPUT_LINE <= shift_out_reg[WIDTH-2];
          end
        end
        if (sample_edge && bit_count_reg < WIDTH) begin
          shift_in_reg  <= {shift_in_reg[WIDTH-2:0], din_sync_reg[1]};
          bit_count_reg <= bit_count_reg + 5'h01;
          if (bit_count_reg == WIDTH - 1) begin                         // [RQ7]
            RX_WORD  <= {shift_in_reg[WIDTH-2:0], din_sync_reg[1]};
            RX_VALID <= 1'b1;
          end
        end
      end
    end
  end

  // flags a serial period shorter than the prescale bound; sticky until reset
  always @(posedge CLK) begin
    if (SYS_RST) begin
      period_count_reg <= 9'h000;
      seen_sample_reg  <= 1'b0;
      CLOCK_TOO_FAST   <= 1'b0;
    end else if (!in_frame) begin
      seen_sample_reg  <= 1'b0;
      period_count_reg <= 9'h000;
    end else if (sample_edge) begin
      if (seen_sample_reg && (period_count_reg + 9'h001) < min_period(prescale_value))
        CLOCK_TOO_FAST <= 1'b1;                                         // [RQ4]
      seen_sample_reg  <= 1'b1;
      period_count_reg <= 9'h000;
    end else if (period_count_reg != 9'h1FF) begin
      period_count_reg <= period_count_reg + 9'h001;
    end
  end

endmodule // spi_peripheral_port

/* verilog/spi_peripheral_port_consts.vh */
// constants for the spi peripheral port
`ifndef SPI_PERIPHERAL_PORT_CONSTS_VH
`define SPI_PERIPHERAL_PORT_CONSTS_VH
`define ROLE_SELECT_BIT      0
`define PHASE_BIT            16
`define POLARITY_BIT         17
`define PRESCALE_MSB         15
`define PRESCALE_LSB         8
`define WORD_BITS            16
`define BIT_COUNT_RESET      5'h00
`define MIN_SCLK_PERIOD_NS   25
`define CLK_PERIOD_NS        4
`define MIN_SCLK_CYCLES      ((`MIN_SCLK_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif
